/* File: hdl/rsse_exec.sv */
// Execution unit for rotate right, sleep and subtract instructions.
// Assumes software loads instruction and operand over APB, then starts it.
//
// Contract
// - Destination bit clear writes accumulator; set writes file register.
// - Plain rotate right moves bit0 to bit7; updates N and Z only.
// - Bank bit clear with extension on and address <= 95 is indexed.
// - Sleep clears power-down flag and sets time-out flag.
// - Sleep clears watchdog counter and postscaler, then halts.
// - Wake by watchdog timeout leaves time-out flag cleared.
// - Acc minus file minus inverted carry; updates N OV C DC Z.
// - Literal minus acc, always into acc, single cycle.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
module rsse_exec
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             halted,
    output logic             file_we,
    output logic      [7:0]  file_wdata
);
    import rsse_pkg::*;

    typedef struct packed
    {
        rsse_state_e state;
        logic [2:0]  ctrl;
        logic [15:0] instr;
        logic [7:0]  fval;
        logic [7:0]  acc;
        logic [7:0]  status;
        logic        indexed;
        logic [15:0] wdt;
        logic [3:0]  post;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        halted;
        logic        file_we;
        logic [7:0]  file_wdata;
    } rsse_regs_s;

    rsse_regs_s  st_reg;
    rsse_regs_s  st_next;
    rsse_alu_if  alu_bus();
    logic        acc_phase;
    logic        wr_en;
    logic [5:0]  op6;
    logic [2:0]  sel;
    logic        ctrl_wr;

    rsse_alu u_alu
    (
        .a (alu_bus)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign acc_phase = psel & penable;
    assign wr_en     = acc_phase & pwrite & pstrb[0];
    assign ctrl_wr   = wr_en & ~st_reg.pready & (paddr == RSSE_CTRL_OFF);
    assign op6       = st_reg.instr[15:10];

    // ----------------------------------------------------------------
    // Opcode decode
    // ----------------------------------------------------------------
    // Any other opcode selects code 0; unless it is SLEEP, a start with it changes only the indexed flag, which it clears.
    always_comb
    begin
        sel = 3'd0;
        if (op6 == RSSE_OP_RRN)
            sel = 3'd1;
        else if (op6 == RSSE_OP_RRC)
            sel = 3'd2;
        else if (op6 == RSSE_OP_SFWB)
            sel = 3'd3;
        else if (st_reg.instr[15:8] == RSSE_OP_SUBL)
            sel = 3'd4;
    end

    assign alu_bus.acc  = st_reg.acc;
    assign alu_bus.fval = st_reg.fval;
    assign alu_bus.lit  = st_reg.instr[7:0];
    assign alu_bus.sel  = sel;
    assign alu_bus.cin  = st_reg.status[RSSE_ST_C];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next         = st_reg;
        st_next.pready  = acc_phase & ~st_reg.pready;
        st_next.pslverr = 1'b0;
        st_next.file_we = 1'b0;
        if (acc_phase & ~st_reg.pready & ~pwrite)
        begin
            case (paddr)
                RSSE_CTRL_OFF:   st_next.prdata = {29'h0, st_reg.ctrl};
                RSSE_INSTR_OFF:  st_next.prdata = {16'h0, st_reg.instr};
                RSSE_FILE_OFF:   st_next.prdata = {24'h0, st_reg.fval};
                RSSE_ACC_OFF:    st_next.prdata = {24'h0, st_reg.acc};
                RSSE_STATUS_OFF: st_next.prdata = {24'h0, st_reg.status};
                RSSE_ADDR_OFF:   st_next.prdata = {31'h0, st_reg.indexed};
                RSSE_WDT_OFF:    st_next.prdata = {12'h0, st_reg.post, st_reg.wdt};
                default:
                begin
                    st_next.prdata  = 32'h0;
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_en & ~st_reg.pready)
        begin
            case (paddr)
                RSSE_CTRL_OFF:   st_next.ctrl  = pwdata[2:0];
                RSSE_INSTR_OFF:  st_next.instr = pwdata[15:0];
                RSSE_FILE_OFF:   st_next.fval  = pwdata[7:0];
                RSSE_ACC_OFF:    st_next.acc   = pwdata[7:0];
                RSSE_STATUS_OFF: st_next.status[4:0] = pwdata[4:0];
                default:         st_next.pslverr = ~(paddr == RSSE_ADDR_OFF || paddr == RSSE_WDT_OFF);
            endcase
        end
        if (st_reg.state != RSSE_SLEEP)
            st_next.wdt = st_reg.wdt + 16'h0001;
        case (st_reg.state)
            RSSE_IDLE:
            begin
                if (ctrl_wr & pwdata[RSSE_CTRL_WAKE_BIT])
                    st_next.state = RSSE_EXEC;
            end
            RSSE_EXEC:
            begin
                st_next.state = RSSE_IDLE;
                st_next.indexed = ~st_reg.instr[8] & st_reg.ctrl[RSSE_CTRL_EXT_BIT]
                                  & (st_reg.instr[7:0] <= RSSE_ILO_LIMIT) & (sel != 3'd4) & (sel != 3'd0);
                if (st_reg.instr == RSSE_OP_SLEEP)
                begin
                    st_next.status[RSSE_ST_PD] = 1'b0;
                    st_next.status[RSSE_ST_TO] = 1'b1;
                    st_next.wdt    = RSSE_WDT_RST;
                    st_next.post   = RSSE_POST_RST;
                    st_next.state  = RSSE_SLEEP;
                    st_next.halted = 1'b1;
                end
                else if (sel != 3'd0)
                begin
                    st_next.status[RSSE_ST_Z] = (alu_bus.res == RSSE_ZERO8);
                    st_next.status[RSSE_ST_N] = alu_bus.res[7];
                    if (sel != 3'd1)
                        st_next.status[RSSE_ST_C] = alu_bus.c;
                    if (sel[2] | (sel == 3'd3))
                    begin
                        st_next.status[RSSE_ST_DC] = alu_bus.dc;
                        st_next.status[RSSE_ST_OV] = alu_bus.ov;
                    end
                    if ((sel != 3'd4) & st_reg.instr[9])
                    begin
                        st_next.fval       = alu_bus.res;
                        st_next.file_we    = 1'b1;
                        st_next.file_wdata = alu_bus.res;
                    end
                    else
                        st_next.acc = alu_bus.res;
                end
            end
            RSSE_SLEEP:
            begin
                if (ctrl_wr & pwdata[RSSE_CTRL_WDTW_BIT])
                begin
                    st_next.status[RSSE_ST_TO] = 1'b0;
                    st_next.state  = RSSE_IDLE;
                    st_next.halted = 1'b0;
                end
                else if (ctrl_wr & pwdata[RSSE_CTRL_WAKE_BIT])
                begin
                    st_next.state  = RSSE_IDLE;
                    st_next.halted = 1'b0;
                end
            end
            default: st_next.state = RSSE_IDLE;
        endcase
        // Start and wake bits are strobes; they never read back set in any state.
        st_next.ctrl[2:1] = 2'b00;
        st_next.status[RSSE_ST_SL] = (st_next.state == RSSE_SLEEP);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Status comes up with both power flags set, as after a power-on.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg        <= '0;
            st_reg.state  <= RSSE_IDLE;
            st_reg.status <= RSSE_STATUS_RST;
        end
        else
            st_reg <= st_next;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata     = st_reg.prdata;
    assign pready     = st_reg.pready;
    assign pslverr    = st_reg.pslverr;
    assign halted     = st_reg.halted;
    assign file_we    = st_reg.file_we;
    assign file_wdata = st_reg.file_wdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_exec_sleep;
        st_reg.state == RSSE_EXEC && st_reg.instr == RSSE_OP_SLEEP;
    endsequence

    sequence s_exec_sfwb;
        st_reg.state == RSSE_EXEC && sel == 3'd3;
    endsequence

    sequence s_exec_subl;
        st_reg.state == RSSE_EXEC && sel == 3'd4;
    endsequence

    chk_sleep_flags: assert property (@(posedge pclk) disable iff (!presetn)
        s_exec_sleep |=> !st_reg.status[RSSE_ST_PD] && st_reg.status[RSSE_ST_TO])
        else $error("sleep flags wrong");
    chk_sleep_wdt: assert property (@(posedge pclk) disable iff (!presetn)
        s_exec_sleep |=> st_reg.wdt == 16'h0000 && st_reg.post == 4'h0 && halted)
        else $error("sleep did not clear watchdog");
    chk_rrn_value: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd1 && !st_reg.instr[9] |=>
        st_reg.acc == {$past(st_reg.fval[0]), $past(st_reg.fval[7:1])})
        else $error("plain rotate wrong");
    chk_rrn_carry: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd1 |=> $stable(st_reg.status[RSSE_ST_C]))
        else $error("plain rotate touched carry");
    chk_rrc_carry: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd2 |=> st_reg.status[RSSE_ST_C] == $past(st_reg.fval[0]))
        else $error("rotate carry wrong");
    chk_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel inside {3'd1, 3'd2, 3'd3} && st_reg.instr[9] |=> file_we && $stable(st_reg.acc))
        else $error("destination wrong");
    chk_subl_acc: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd4 |=>
        st_reg.acc == $past(st_reg.instr[7:0]) - $past(st_reg.acc) && !file_we)
        else $error("literal subtract wrong");
    chk_sub_carry: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd4 |=> st_reg.status[RSSE_ST_C] == ($past(st_reg.instr[7:0]) >= $past(st_reg.acc)))
        else $error("subtract carry wrong");
    chk_sfwb_value: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd3 && !st_reg.instr[9] |=>
        st_reg.acc == $past(st_reg.acc) - $past(st_reg.fval) - {7'h0, !$past(st_reg.status[RSSE_ST_C])})
        else $error("borrow subtract wrong");
    chk_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_SLEEP && wr_en && !pready && paddr == RSSE_CTRL_OFF && pwdata[RSSE_CTRL_WDTW_BIT]
        |=> !st_reg.status[RSSE_ST_TO] && !halted)
        else $error("watchdog wake flag wrong");
    chk_indexed_addr: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd1 && !st_reg.instr[8] && st_reg.ctrl[0] && st_reg.instr[7:0] <= 8'h5F
        |=> st_reg.indexed)
        else $error("indexed mode missed");
    chk_rrc_value: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd2 && !st_reg.instr[9] |=>
        st_reg.acc == {$past(st_reg.status[RSSE_ST_C]), $past(st_reg.fval[7:1])})
        else $error("rotate via carry value wrong");
    chk_rrn_file: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel == 3'd1 && st_reg.instr[9] |=>
        file_wdata == {$past(st_reg.fval[0]), $past(st_reg.fval[7:1])}
        && $stable(st_reg.status[RSSE_ST_OV]) && $stable(st_reg.status[RSSE_ST_DC]))
        else $error("plain rotate to file wrong");
    chk_sfwb_carry: assert property (@(posedge pclk) disable iff (!presetn)
        s_exec_sfwb |=> st_reg.status[RSSE_ST_C] ==
        ({1'b0, $past(st_reg.acc)} >= {1'b0, $past(st_reg.fval)} + {8'h00, !$past(st_reg.status[RSSE_ST_C])}))
        else $error("borrow subtract carry wrong");
    chk_sfwb_dc: assert property (@(posedge pclk) disable iff (!presetn)
        s_exec_sfwb |=> st_reg.status[RSSE_ST_DC] ==
        ({1'b0, $past(st_reg.acc[3:0])} >=
        {1'b0, $past(st_reg.fval[3:0])} + {4'h0, !$past(st_reg.status[RSSE_ST_C])}))
        else $error("borrow subtract digit carry wrong");
    chk_sfwb_ov: assert property (@(posedge pclk) disable iff (!presetn)
        s_exec_sfwb |=> st_reg.status[RSSE_ST_OV] == (($past(st_reg.acc[7]) ^ $past(st_reg.fval[7]))
        & ($past(st_reg.acc[7]) ^ st_reg.status[RSSE_ST_N])))
        else $error("borrow subtract overflow wrong");
    chk_subl_flags: assert property (@(posedge pclk) disable iff (!presetn)
        s_exec_subl |=> st_reg.status[RSSE_ST_Z] == (st_reg.acc == RSSE_ZERO8)
        && st_reg.status[RSSE_ST_N] == st_reg.acc[7])
        else $error("literal subtract zero or negative wrong");
    chk_acc_dest: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_EXEC && sel inside {3'd1, 3'd2, 3'd3} && !st_reg.instr[9] |=> !file_we)
        else $error("accumulator destination wrote file");
    chk_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.state == RSSE_SLEEP && !ctrl_wr |=> halted && st_reg.wdt == RSSE_WDT_RST)
        else $error("sleep left without wake");
endmodule

/* File: hdl/rsse_pkg.sv */
// Package for the rotate, sleep and subtract execution block.
// Assumes a single clock domain and APB access from software.
package rsse_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] RSSE_CTRL_OFF   = 12'h000;
    localparam logic [11:0] RSSE_INSTR_OFF  = 12'h004;
    localparam logic [11:0] RSSE_FILE_OFF   = 12'h008;
    localparam logic [11:0] RSSE_ACC_OFF    = 12'h00C;
    localparam logic [11:0] RSSE_STATUS_OFF = 12'h010;
    localparam logic [11:0] RSSE_ADDR_OFF   = 12'h014;
    localparam logic [11:0] RSSE_WDT_OFF    = 12'h018;
    // Control bits.
    localparam int RSSE_CTRL_EXT_BIT  = 0;
    localparam int RSSE_CTRL_WAKE_BIT = 1;
    localparam int RSSE_CTRL_WDTW_BIT = 2;
    // Status field positions.
    localparam int RSSE_ST_C  = 0;
    localparam int RSSE_ST_DC = 1;
    localparam int RSSE_ST_Z  = 2;
    localparam int RSSE_ST_OV = 3;
    localparam int RSSE_ST_N  = 4;
    localparam int RSSE_ST_PD = 5;
    localparam int RSSE_ST_TO = 6;
    localparam int RSSE_ST_SL = 7;
    // Reset values and constants.
    localparam logic [7:0]  RSSE_STATUS_RST = 8'h60;
    localparam logic [7:0]  RSSE_ZERO8      = 8'h00;
    localparam logic [7:0]  RSSE_ILO_LIMIT  = 8'h5F;
    localparam logic [15:0] RSSE_WDT_RST    = 16'h0000;
    localparam logic [3:0]  RSSE_POST_RST   = 4'h0;
    // ----------------------------------------------------------------
    // Operation codes, instruction bits [15:10]; literal subtract uses bits [15:8], sleep the whole word
    // ----------------------------------------------------------------
    localparam logic [5:0] RSSE_OP_RRC  = 6'h0C;
    localparam logic [5:0] RSSE_OP_RRN  = 6'h10;
    localparam logic [5:0] RSSE_OP_SFWB = 6'h15;
    localparam logic [7:0] RSSE_OP_SUBL = 8'h08;
    localparam logic [15:0] RSSE_OP_SLEEP = 16'h0003;

    typedef enum logic [2:0]
    {
        RSSE_IDLE  = 3'b001,
        RSSE_EXEC  = 3'b010,
        RSSE_SLEEP = 3'b100
    } rsse_state_e;
endpackage

/* File: hdl/rsse_alu_if.sv */
// Interface carrying operands and results between the block and its ALU.
// Assumes the ALU is purely combinational.
`timescale 1ns/1ns
interface rsse_alu_if;
    logic [7:0] acc;
    logic [7:0] fval;
    logic [7:0] lit;
    logic [2:0] sel;
    logic       cin;
    logic [7:0] res;
    logic       c;
    logic       dc;
    logic       ov;
    modport core (output acc, fval, lit, sel, cin, input res, c, dc, ov);
    modport alu  (input acc, fval, lit, sel, cin, output res, c, dc, ov);
endinterface

/* File: hdl/rsse_alu.sv */
// Combinational arithmetic for the rotate and subtract operations.
// Assumes operands are stable within one clock cycle.
`timescale 1ns/1ns
module rsse_alu
(
    rsse_alu_if.alu a
);
    import rsse_pkg::*;

    function automatic logic [9:0] rsse_sub(input logic [7:0] x, input logic [7:0] y, input logic bin);
        logic [8:0] s;
        logic [4:0] l;
        s = {1'b0, x} - {1'b0, y} - {8'h00, bin};
        l = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, bin};
        // Carry and digit carry are the inverse of the borrows out of bit 7 and bit 3.
        rsse_sub = {~l[4], ~s[8], s[7:0]};
    endfunction

    logic [9:0] sub_r;

    always_comb
    begin
        sub_r = 10'h000;
        a.res = 8'h00;
        a.c   = 1'b0;
        a.dc  = 1'b0;
        a.ov  = 1'b0;
        case (a.sel)
            3'd1:
            begin
                a.res = {a.fval[0], a.fval[7:1]};
            end
            3'd2:
            begin
                a.res = {a.cin, a.fval[7:1]};
                a.c   = a.fval[0];
            end
            3'd3:
            begin
                sub_r = rsse_sub(a.acc, a.fval, ~a.cin);
                a.res = sub_r[7:0];
                a.c = sub_r[8];
                a.ov = (a.acc[7] ^ a.fval[7]) & (a.acc[7] ^ sub_r[7]);
                a.dc = sub_r[9];
            end
            3'd4:
            begin
                sub_r = rsse_sub(a.lit, a.acc, 1'b0);
                a.res = sub_r[7:0];
                a.c = sub_r[8];
                a.ov = (a.lit[7] ^ a.acc[7]) & (a.lit[7] ^ sub_r[7]);
                a.dc = sub_r[9];
            end
            default:
            begin
                a.res = 8'h00;
            end
        endcase
    end
endmodule

/* File: verif/test_rotate_sleep_subtract_exec.sv */
// Self-checking bench for the rotate, sleep and subtract execution block.
// Assumes the block answers APB within a few cycles and runs one op per start.
`timescale 1ns/1ns
module test_rotate_sleep_subtract_exec;
    import rsse_pkg::*;
    typedef struct packed
    {
        logic [15:0] ins;
        logic [7:0]  fin;
        logic [7:0]  ain;
        logic [7:0]  sin;
        logic [7:0]  efile;
        logic [7:0]  eacc;
        logic [7:0]  est;
        logic        ewe;
    } rsse_row_s;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        halted;
    logic        file_we;
    logic [7:0]  file_wdata;
    int          fail_count = 0;
    int          num_checks = 0;
    int          we_cnt     = 0;
    logic [7:0]  we_data;
    logic [31:0] rd;
    logic        err;
    rsse_row_s   rows [14];

    rsse_exec dut
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .pstrb      (pstrb),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .halted     (halted),
        .file_we    (file_we),
        .file_wdata (file_wdata)
    );

    always #20 pclk = ~pclk;

    // Write-back strobes are a single cycle, so they are counted as they pass.
    always @(posedge pclk)
    begin
        if (file_we === 1'b1)
        begin
            we_cnt  <= we_cnt + 1;
            we_data <= file_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
        begin
            fail_count++;
            $display("unexpected at %0t: pready %h expected %h", $time, pready, 1'b1);
            end_sim;
        end
        else
        begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        check(rd, exp);
    endtask

    task automatic run_row(input rsse_row_s r);
        int base;
        wr(RSSE_FILE_OFF, {24'h0, r.fin});
        wr(RSSE_ACC_OFF, {24'h0, r.ain});
        wr(RSSE_STATUS_OFF, {24'h0, r.sin});
        wr(RSSE_INSTR_OFF, {16'h0, r.ins});
        base = we_cnt;
        wr(RSSE_CTRL_OFF, 32'h0000_0002);
        rchk(RSSE_FILE_OFF, {24'h0, r.efile});
        rchk(RSSE_ACC_OFF, {24'h0, r.eacc});
        rchk(RSSE_STATUS_OFF, {24'h0, 3'b011, r.est[4:0]});
        check(32'(we_cnt - base), {31'h0, r.ewe});
        if (r.ewe)
            check({24'h0, we_data}, {24'h0, r.efile});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        pclk    = 1'b0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
        rows = '{'{16'h4320, 8'hD7, 8'h55, 8'h0B, 8'hEB, 8'h55, 8'h1B, 1'b1},
                 '{16'h4120, 8'h01, 8'h00, 8'h10, 8'h01, 8'h80, 8'h10, 1'b0},
                 '{16'h4120, 8'h00, 8'h33, 8'h0B, 8'h00, 8'h00, 8'h0F, 1'b0},
                 '{16'h3120, 8'hE6, 8'h11, 8'h00, 8'hE6, 8'h73, 8'h00, 1'b0},
                 '{16'h3320, 8'h02, 8'h22, 8'h0B, 8'h81, 8'h22, 8'h1A, 1'b1},
                 '{16'h3320, 8'h01, 8'h22, 8'h00, 8'h00, 8'h22, 8'h05, 1'b1},
                 '{16'h5720, 8'h03, 8'h02, 8'h01, 8'hFF, 8'h02, 8'h10, 1'b1},
                 '{16'h5520, 8'h02, 8'h05, 8'h01, 8'h02, 8'h03, 8'h03, 1'b0},
                 '{16'h5720, 8'h01, 8'h02, 8'h00, 8'h00, 8'h02, 8'h07, 1'b1},
                 '{16'h5520, 8'h01, 8'h80, 8'h01, 8'h01, 8'h7F, 8'h09, 1'b0},
                 '{16'h0802, 8'h44, 8'h01, 8'h1F, 8'h44, 8'h01, 8'h03, 1'b0},
                 '{16'h0802, 8'h44, 8'h02, 8'h00, 8'h44, 8'h00, 8'h07, 1'b0},
                 '{16'h0802, 8'h44, 8'h03, 8'h00, 8'h44, 8'hFF, 8'h10, 1'b0},
                 '{16'h087F, 8'h44, 8'hFF, 8'h00, 8'h44, 8'h80, 8'h1A, 1'b0}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(RSSE_STATUS_OFF, 32'h0000_0060);
        for (int i = 0; i < 14; i++)
            run_row(rows[i]);
        // An unmapped place must answer with an error and no data.
        apb(1'b0, 12'h01C, 32'h0000_0000, 4'hF);
        check({31'h0, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        apb(1'b1, RSSE_ACC_OFF, 32'h0000_00AA, 4'hE);
        rchk(RSSE_ACC_OFF, 32'h0000_0080);
        // Indexed addressing at both sides of the limit, then with extension off.
        wr(RSSE_INSTR_OFF, 32'h0000_405F);
        wr(RSSE_CTRL_OFF, 32'h0000_0003);
        apb(1'b0, RSSE_ADDR_OFF, 32'h0000_0000, 4'hF);
        check({31'h0, rd[0]}, 32'h0000_0001);
        wr(RSSE_INSTR_OFF, 32'h0000_4060);
        wr(RSSE_CTRL_OFF, 32'h0000_0003);
        apb(1'b0, RSSE_ADDR_OFF, 32'h0000_0000, 4'hF);
        check({31'h0, rd[0]}, 32'h0000_0000);
        wr(RSSE_INSTR_OFF, 32'h0000_405F);
        wr(RSSE_CTRL_OFF, 32'h0000_0002);
        apb(1'b0, RSSE_ADDR_OFF, 32'h0000_0000, 4'hF);
        check({31'h0, rd[0]}, 32'h0000_0000);
        // Sleep, normal wake, sleep again, watchdog wake.
        apb(1'b0, RSSE_WDT_OFF, 32'h0000_0000, 4'hF);
        check({31'h0, rd[15:0] != 16'h0000}, 32'h0000_0001);
        wr(RSSE_INSTR_OFF, {16'h0, RSSE_OP_SLEEP});
        wr(RSSE_CTRL_OFF, 32'h0000_0002);
        rchk(RSSE_WDT_OFF, 32'h0000_0000);
        apb(1'b0, RSSE_STATUS_OFF, 32'h0000_0000, 4'hF);
        check({30'h0, rd[6:5]}, 32'h0000_0002);
        check({31'h0, halted}, 32'h0000_0001);
        wr(RSSE_CTRL_OFF, 32'h0000_0002);
        apb(1'b0, RSSE_STATUS_OFF, 32'h0000_0000, 4'hF);
        check({31'h0, halted}, 32'h0000_0000);
        wr(RSSE_INSTR_OFF, {16'h0, RSSE_OP_SLEEP});
        wr(RSSE_CTRL_OFF, 32'h0000_0002);
        wr(RSSE_CTRL_OFF, 32'h0000_0004);
        apb(1'b0, RSSE_STATUS_OFF, 32'h0000_0000, 4'hF);
        check({30'h0, rd[6:5]}, 32'h0000_0000);
        check({31'h0, halted}, 32'h0000_0000);
        // A second reset in mid-run must restore the power-up status.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk(RSSE_STATUS_OFF, 32'h0000_0060);
        rchk(RSSE_ACC_OFF, 32'h0000_0000);
        end_sim;
    end
endmodule
